// file: core/srrc_top.v
// Standby RAM retention controller: freeze state, supply switch, strobe isolation.
// Assumes supply comparators and reset inputs arrive synchronous to CLK.
`timescale 1ns/1ps
`include "srrc_regs.vh"
// Function
// - Clearing enable freezes RAM interface immediately
// - Reset switches RAM to standby supply
// - Frozen until enable set after power-on
// - Low core supply forces freeze only while enable is clear
// - Brief dip with enable set ignored
// - Isolation blocks core strobes during transient
// - Detector holds reset below one volt
// - Reset release returns RAM to core
// - Clock counts standby only on 32 kHz
// - Reset disables RAM and freezes interface
module srrc_top #(
  parameter DIP_CYC = `SRRC_DIP_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  input wire CE,
  // Reset sources
  input wire RESET_INPUT_PIN_N,
  input wire CORE_ABOVE_1V0,
  // Supply comparator and software control
  input wire CORE_ABOVE_STBY_REF,
  input wire STANDBY_RAM_ENABLE,
  // Clock reference selection
  input wire RTC_USE_LP_OSC,
  input wire MAIN_SUPPLY_ON,
  // Core RAM strobes
  input wire CORE_WE_N,
  input wire CORE_CE_N,
  // RAM side
  output wire RAM_WE_N,
  output wire RAM_CE_N,
  output reg RAM_FROZEN,
  output reg RAM_SUPPLY_SEL,
  output reg INTERNAL_RESET,
  output reg RTC_COUNT_EN,
  output wire [3:0] STATE
);
  localparam S_RUN = `SRRC_ST_RUN;
  localparam S_RESET = `SRRC_ST_RESET;
  localparam S_STBY = `SRRC_ST_STBY;
  localparam S_FROZEN = `SRRC_ST_FROZEN;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] dip_q;
  reg en_q;
  wire rst_req;
  wire low_core;
  wire en_rise;

  assign rst_req = ~RESET_INPUT_PIN_N | ~CORE_ABOVE_1V0;
  assign low_core = (dip_q >= DIP_CYC[7:0]);
  assign en_rise = STANDBY_RAM_ENABLE & ~en_q;
  assign STATE = state_q;

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_FROZEN;
      dip_q <= 8'h00;
      en_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      en_q <= STANDBY_RAM_ENABLE;
      if (CORE_ABOVE_STBY_REF)
        dip_q <= 8'h00;
      else if (dip_q != 8'hFF)
        dip_q <= dip_q + 8'h01;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (rst_req)
          state_d = S_RESET;
        else if (!STANDBY_RAM_ENABLE)
          state_d = S_FROZEN;
      end
      S_RESET: begin
        if (!CORE_ABOVE_STBY_REF)
          state_d = S_STBY;
        else if (!rst_req)
          state_d = S_FROZEN;
      end
      S_STBY: begin
        if (CORE_ABOVE_STBY_REF && !rst_req)
          state_d = S_FROZEN;
      end
      S_FROZEN: begin
        if (rst_req)
          state_d = S_RESET;
        else if (en_rise && CORE_ABOVE_STBY_REF)
          state_d = S_RUN;
      end
      default: state_d = S_FROZEN;
    endcase
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      RAM_FROZEN <= 1'b1;
      RAM_SUPPLY_SEL <= `SRRC_SUP_STBY;
      INTERNAL_RESET <= 1'b1;
      RTC_COUNT_EN <= 1'b0;
    end else if (CE) begin
      RAM_FROZEN <= (state_d != S_RUN) | (low_core & ~STANDBY_RAM_ENABLE);
      RAM_SUPPLY_SEL <= (state_d == S_RESET || state_d == S_STBY) ? `SRRC_SUP_STBY : `SRRC_SUP_CORE;
      INTERNAL_RESET <= rst_req;
      RTC_COUNT_EN <= RTC_USE_LP_OSC | MAIN_SUPPLY_ON;
    end
  end

  srrc_iso u_iso (
    .block(RAM_FROZEN | ~STANDBY_RAM_ENABLE),
    .core_we_n(CORE_WE_N),
    .core_ce_n(CORE_CE_N),
    .ram_we_n(RAM_WE_N),
    .ram_ce_n(RAM_CE_N)
  );
endmodule // srrc_top

// file: core/srrc_regs.vh
// Constants for the standby RAM retention controller.
// Assumes inclusion by bare name from the design files.
`ifndef SRRC_REGS_VH
`define SRRC_REGS_VH
`define SRRC_SUP_CORE 1'b0
`define SRRC_SUP_STBY 1'b1
`define SRRC_ST_RUN 4'h1
`define SRRC_ST_RESET 4'h2
`define SRRC_ST_STBY 4'h4
`define SRRC_ST_FROZEN 4'h8
`define SRRC_DIP_NS 16
`define SRRC_CLK_NS 8
`define SRRC_DIP_CYC ((`SRRC_DIP_NS + `SRRC_CLK_NS - 1) / `SRRC_CLK_NS)
`endif

// file: core/srrc_iso.v
// Isolation stage between core RAM strobes and the retained RAM.
// Assumes it sits in the switched supply domain; strobes are active low.
`timescale 1ns/1ps
module srrc_iso (
  // Control
  input wire block,
  // Core side strobes
  input wire core_we_n,
  input wire core_ce_n,
  // RAM side strobes
  output wire ram_we_n,
  output wire ram_ce_n
);
  // Blocked strobes are forced inactive so a sagging write level cannot reach the RAM.
  assign ram_we_n = core_we_n | block;
  assign ram_ce_n = core_ce_n | block;
endmodule // srrc_iso

// file: test/srrc_sva.sv
// Port checker for srrc_top.
// Assumes CE is tied high.
`timescale 1ns/1ps
module srrc_sva (input wire CLK, RST, RESET_INPUT_PIN_N, CORE_ABOVE_1V0, CORE_ABOVE_STBY_REF,
  STANDBY_RAM_ENABLE, RTC_USE_LP_OSC, MAIN_SUPPLY_ON, RAM_WE_N, RAM_CE_N, RAM_FROZEN,
  RAM_SUPPLY_SEL, INTERNAL_RESET, RTC_COUNT_EN);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  iso_block_a: assert property (RAM_FROZEN || !STANDBY_RAM_ENABLE |-> RAM_WE_N && RAM_CE_N)
    else $error("iso");
  clr_freeze_a: assert property (!STANDBY_RAM_ENABLE |=> RAM_FROZEN) else $error("clr");
  low_hold_a: assert property (RAM_FROZEN && !CORE_ABOVE_STBY_REF |=> RAM_FROZEN) else $error("low");
  rst_switch_a: assert property (!RESET_INPUT_PIN_N |=> RAM_SUPPLY_SEL && INTERNAL_RESET)
    else $error("rst");
  lvd_hold_a: assert property (!CORE_ABOVE_1V0 |=> INTERNAL_RESET) else $error("lvd");
  dip_ignore_a: assert property (!RAM_FROZEN && STANDBY_RAM_ENABLE && RESET_INPUT_PIN_N && CORE_ABOVE_1V0
    |=> !RAM_FROZEN) else $error("dip");
  core_back_a: assert property (INTERNAL_RESET && RESET_INPUT_PIN_N && CORE_ABOVE_1V0 && CORE_ABOVE_STBY_REF
    |-> ##[1:3] !RAM_SUPPLY_SEL) else $error("back");
  rtc_stop_a: assert property (!RTC_USE_LP_OSC && !MAIN_SUPPLY_ON |=> !RTC_COUNT_EN) else $error("rtc");
endmodule // srrc_sva

// file: test/srrc_supply_model.sv
// Supply and reset supervisor stand-in.
// Assumes the bench steps power at falling edges.
`timescale 1ns/1ps
module srrc_supply_model (input wire CLK, pwr, dip, output reg main_on = 0, v1 = 0, ref_ok = 0, pin_n = 0);
  integer cnt = 0;
  always @(negedge CLK) begin
    cnt = pwr ? cnt + (cnt < 9) : 0;
    main_on = pwr;
    v1 = cnt > 1;
    ref_ok = cnt > 3 && !dip;
    // Pin held low until the supply settles.
    pin_n = cnt > 6;
  end
endmodule // srrc_supply_model

// file: test/standby_ram_retention_control_test.sv
// Directed bench for the retention controller.
// Assumes the supply model drives the reset pin.
`timescale 1ns/1ps
`include "srrc_regs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s %h %h", n, e, a); end end
bind srrc_top srrc_sva i_sva (.*);
module standby_ram_retention_control_test;
  reg clk = 0, rst = 1, pwr = 0, dip = 0, en = 0, lp = 0, we_n = 1;
  wire main_on, v1, ref_ok, pin_n, ram_we_n, ram_ce_n, frz, sel, ir, rtc;
  wire [3:0] st;
  integer mismatches = 0, comparisons = 0, cycles = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (++cycles > 400) begin
    mismatches++;
    print_verdict;
  end
  srrc_supply_model i_sup (.CLK(clk), .pwr(pwr), .dip(dip), .main_on(main_on), .v1(v1), .ref_ok(ref_ok), .pin_n(pin_n));
  srrc_top i_dut (.CLK(clk), .RST(rst), .CE(1'b1), .RESET_INPUT_PIN_N(pin_n), .CORE_ABOVE_1V0(v1),
    .CORE_ABOVE_STBY_REF(ref_ok), .STANDBY_RAM_ENABLE(en), .RTC_USE_LP_OSC(lp), .MAIN_SUPPLY_ON(main_on),
    .CORE_WE_N(we_n), .CORE_CE_N(we_n), .RAM_WE_N(ram_we_n), .RAM_CE_N(ram_ce_n), .RAM_FROZEN(frz),
    .RAM_SUPPLY_SEL(sel), .INTERNAL_RESET(ir), .RTC_COUNT_EN(rtc), .STATE(st));
  task power_up;
    pwr = 1;
    repeat (12) @(negedge clk);
    `CHK("sel", 1'b0, sel)
    `CHK("state", `SRRC_ST_FROZEN, st)
  endtask
  task unfreeze_dip;
    en = 1;
    @(negedge clk);
    we_n = 0;
    #1 `CHK("we", 1'b0, ram_we_n)
    `CHK("ce", 1'b0, ram_ce_n)
    dip = 1;
    repeat (3) @(negedge clk);
    `CHK("dip", 1'b0, frz)
    dip = 0;
  endtask
  task standby;
    en = 0;
    #1 `CHK("blk", 1'b1, ram_we_n)
    `CHK("blkce", 1'b1, ram_ce_n)
    @(negedge clk);
    pwr = 0;
    lp = 1;
    // The model may sample the power step at this falling edge or the next, so allow one edge of slack.
    repeat (3) @(negedge clk);
    `CHK("stby", 1'b1, sel)
    `CHK("rtc", 1'b1, rtc)
    lp = 0;
    repeat (2) @(negedge clk);
    `CHK("rtc0", 1'b0, rtc)
  endtask
  task print_verdict;
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    power_up;
    unfreeze_dip;
    standby;
    power_up;
    print_verdict;
  end
endmodule // standby_ram_retention_control_test
